// *** rtl/plrc_map.svh ***
/*
 * Constants of the power loss restore controller: timing, record layout,
 * policy codes and reset values.
 * Assumes it is included by bare name from the package and the top module.
 */
`ifndef PLRC_MAP_SVH
`define PLRC_MAP_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
// Supervision interval in seconds (30 s)
`define PLRC_WATCH_TIME_S   64'h0000_0000_0000_001E
// Controller clock rate in Hz (100 MHz)
`define PLRC_CLK_HZ         64'h0000_0000_05F5_E100
`define PLRC_WATCH_CYCLES   (`PLRC_WATCH_TIME_S * `PLRC_CLK_HZ)

// ----------------------------------------------------------------------------
// Persistent record
// ----------------------------------------------------------------------------
`define PLRC_REC_ADDR       2'h0
`define PLRC_REC_LAST_ON    0
`define PLRC_REC_LOSS_SEEN  1
`define PLRC_REC_RESET      8'h00

// ----------------------------------------------------------------------------
// Policy codes
// ----------------------------------------------------------------------------
`define PLRC_POL_TURN_ON    2'h0
`define PLRC_POL_REMAIN_OFF 2'h1
`define PLRC_POL_LAST_STATE 2'h2

`endif

// *** rtl/plrc_pkg.sv ***
/*
 * Types of the power loss restore controller.
 * Assumes plrc_map.svh is on the include path.
 */
`include "plrc_map.svh"

package plrc_pkg;

    // ------------------------------------------------------------------------
    // States, Gray coded along boot, decide, on, watch, off
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        PLRC_ST_BOOT   = 3'h0,
        PLRC_ST_DECIDE = 3'h1,
        PLRC_ST_ON     = 3'h3,
        PLRC_ST_WATCH  = 3'h2,
        PLRC_ST_OFF    = 3'h6,
        PLRC_ST_LOST   = 3'h7
    } plrc_state_t;

    typedef enum logic [1:0] {
        PLRC_POL_TURN_ON    = `PLRC_POL_TURN_ON,
        PLRC_POL_REMAIN_OFF = `PLRC_POL_REMAIN_OFF,
        PLRC_POL_LAST_STATE = `PLRC_POL_LAST_STATE,
        PLRC_POL_RSVD       = 2'h3
    } plrc_policy_t;

    // ------------------------------------------------------------------------
    // Persistent record word and status bundle
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [5:0] rsvd;
        logic       loss_seen;
        logic       last_on;
    } plrc_record_t;

    typedef struct packed {
        logic        system_on;
        logic        supervising;
        logic        orderly_off;
        logic        power_loss;
        plrc_state_t state;
    } plrc_status_t;

endpackage : plrc_pkg

// *** rtl/plrc_nv_store.sv ***
/*
 * Small persistent store for the on/off record, read data registered.
 * Assumes the array is kept alive across loss of standby power; only the
 * read register is reset.
 */
`timescale 1ns/1ps
`default_nettype none

module plrc_nv_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Write port
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    // Read port
    input  wire logic                     rd_en,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);

    // Erased store reads as zero; never touched by reset on purpose
    logic [WIDTH-1:0] mem_q [DEPTH] = '{default: '0};
    logic [WIDTH-1:0] rd_q;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else if (wr_en) begin
            // Write-through, so the next record update builds on fresh data
            rd_q <= wr_data;
        end else if (rd_en) begin
            rd_q <= mem_q[rd_addr];
        end
    end

    assign rd_data = rd_q;

endmodule : plrc_nv_store

`default_nettype wire

// *** rtl/plrc_top.sv ***
/*
 * Power loss restore controller of the board management controller.
 * Watches the standby rail after an off request under last-state policy, classifies orderly off
 * against power loss, and applies the restore policy when standby returns.
 * Assumes synchronous inputs on SYS_CLK and an external standby-powered
 * inverter behind the supply-on output.
 */
// Overview of operation
// - Supervise standby rail after off request under last-state
// - Stable standby for 30 s: orderly off
// - Standby gone within 30 s: power loss
// - Turn-on policy switches system on on return
// - Remain-off policy keeps system off on return
// - Last-state policy restores prior on/off state
// - Supervision interval used only by last-state
// - No standby rail: policy has no effect
// - Loss during interval leaves record on
// - Request main supply by driving output low
`timescale 1ns/1ps
`default_nettype none
`include "plrc_map.svh"

module plrc_top #(
    parameter logic [31:0] WATCH_CYCLES = 32'(`PLRC_WATCH_CYCLES)
) (
    // Clock and reset
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST_N,
    // Supply status
    input  wire logic                  STANDBY_OK,
    input  wire logic                  STANDBY_RAIL_PRESENT,
    // Configuration
    input  wire logic [1:0]            POLICY,
    // System requests
    input  wire logic                  SYS_ON_REQ,
    input  wire logic                  SYS_OFF_REQ,
    // Supply control and status
    output logic                       SUPPLY_ON_REQUEST_N,
    output plrc_pkg::plrc_status_t     STATUS
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    plrc_pkg::plrc_state_t  state_q;
    plrc_pkg::plrc_state_t  state_d;
    plrc_pkg::plrc_policy_t policy;
    plrc_pkg::plrc_record_t rec_rd;
    plrc_pkg::plrc_record_t rec_wr;
    logic [31:0]            cnt_q;
    logic [31:0]            cnt_d;
    logic [7:0]             rd_word;
    logic                   supply_n_q;
    logic                   loss_q;
    logic                   orderly_q;
    logic                   watch_done;
    logic                   is_last;
    logic                   restore_on;
    logic                   nv_wr;
    logic                   nv_rd;
    logic                   enter_on;
    logic                   enter_off;
    logic                   loss_evt;
    logic                   orderly_evt;

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    assign policy     = plrc_pkg::plrc_policy_t'(POLICY);
    assign is_last    = (policy == plrc_pkg::PLRC_POL_LAST_STATE);
    assign rec_rd     = plrc_pkg::plrc_record_t'(rd_word);
    assign watch_done = (cnt_q >= WATCH_CYCLES - 32'h0000_0001);

    // Restore decision; reserved code behaves as remain-off
    assign restore_on = !STANDBY_RAIL_PRESENT ? 1'b1 :
                        (policy == plrc_pkg::PLRC_POL_TURN_ON) ? 1'b1 :
                        is_last ? rec_rd.last_on :
                        1'b0;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            plrc_pkg::PLRC_ST_BOOT: begin
                state_d = plrc_pkg::PLRC_ST_DECIDE;
            end
            plrc_pkg::PLRC_ST_DECIDE: begin
                if (!STANDBY_OK) begin
                    state_d = plrc_pkg::PLRC_ST_LOST;
                end else if (restore_on) begin
                    state_d = plrc_pkg::PLRC_ST_ON;
                end else begin
                    state_d = plrc_pkg::PLRC_ST_OFF;
                end
            end
            plrc_pkg::PLRC_ST_ON: begin
                if (!STANDBY_OK) begin
                    state_d = plrc_pkg::PLRC_ST_LOST;
                end else if (SYS_OFF_REQ) begin
                    // Interval only matters when the record is consulted
                    state_d = is_last ? plrc_pkg::PLRC_ST_WATCH
                                      : plrc_pkg::PLRC_ST_OFF;
                end
            end
            plrc_pkg::PLRC_ST_WATCH: begin
                if (!STANDBY_OK) begin
                    state_d = plrc_pkg::PLRC_ST_LOST;
                end else if (SYS_ON_REQ) begin
                    state_d = plrc_pkg::PLRC_ST_ON;
                end else if (watch_done) begin
                    state_d = plrc_pkg::PLRC_ST_OFF;
                end
            end
            plrc_pkg::PLRC_ST_OFF: begin
                if (!STANDBY_OK) begin
                    state_d = plrc_pkg::PLRC_ST_LOST;
                end else if (SYS_ON_REQ) begin
                    state_d = plrc_pkg::PLRC_ST_ON;
                end
            end
            plrc_pkg::PLRC_ST_LOST: begin
                // Record is re-read on return so the decision sees fresh data
                if (STANDBY_OK) begin
                    state_d = plrc_pkg::PLRC_ST_BOOT;
                end
            end
            default: begin
                state_d = plrc_pkg::PLRC_ST_BOOT;
            end
        endcase
    end

    assign cnt_d = (state_q == plrc_pkg::PLRC_ST_WATCH) ? cnt_q + 32'h0000_0001 : 32'h0000_0000;

    // ------------------------------------------------------------------------
    // Events and persistent record
    // ------------------------------------------------------------------------
    assign enter_on    = (state_d == plrc_pkg::PLRC_ST_ON) && (state_q != plrc_pkg::PLRC_ST_ON);
    assign enter_off   = (state_d == plrc_pkg::PLRC_ST_OFF) && (state_q != plrc_pkg::PLRC_ST_OFF);
    assign loss_evt    = (state_d == plrc_pkg::PLRC_ST_LOST) && (state_q != plrc_pkg::PLRC_ST_LOST);
    assign orderly_evt = (state_q == plrc_pkg::PLRC_ST_WATCH) && (state_d == plrc_pkg::PLRC_ST_OFF);

    // Off under last-state is written only after the interval, so a loss
    // inside it leaves the record on and the system powers up again
    assign nv_wr = enter_on || enter_off || loss_evt;
    assign nv_rd = (state_q == plrc_pkg::PLRC_ST_BOOT);

    always_comb begin
        rec_wr           = rec_rd;
        rec_wr.rsvd      = 6'h00;
        rec_wr.last_on   = enter_on ? 1'b1 : enter_off ? 1'b0 : rec_rd.last_on;
        rec_wr.loss_seen = loss_evt ? 1'b1 : (enter_on || enter_off) ? 1'b0 : rec_rd.loss_seen;
    end

    plrc_nv_store #(
        .WIDTH (8),
        .DEPTH (4)
    ) u_store (
        .clk     (SYS_CLK),
        .rst_n   (RST_N),
        .wr_en   (nv_wr),
        .wr_addr (`PLRC_REC_ADDR),
        .wr_data (rec_wr),
        .rd_en   (nv_rd | nv_wr),
        .rd_addr (`PLRC_REC_ADDR),
        .rd_data (rd_word)
    );

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_q    <= plrc_pkg::PLRC_ST_BOOT;
            cnt_q      <= 32'h0000_0000;
            supply_n_q <= 1'b1;
            loss_q     <= 1'b0;
            orderly_q  <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            supply_n_q <= (state_d != plrc_pkg::PLRC_ST_ON);
            loss_q     <= loss_evt;
            orderly_q  <= orderly_evt;
        end
    end

    assign SUPPLY_ON_REQUEST_N = supply_n_q;
    assign STATUS = '{
        system_on:   !supply_n_q,
        supervising: (state_q == plrc_pkg::PLRC_ST_WATCH),
        orderly_off: orderly_q,
        power_loss:  loss_q,
        state:       state_q
    };

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    AST_SUPERVISE_START: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_q == plrc_pkg::PLRC_ST_ON) && STANDBY_OK && SYS_OFF_REQ && is_last
        |=> (state_q == plrc_pkg::PLRC_ST_WATCH) && (cnt_q == 32'h0000_0000) ##1 (cnt_q == 32'h0000_0001))
        else $error("Supervision did not start after off request");

    AST_ORDERLY_OFF: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_q == plrc_pkg::PLRC_ST_WATCH) && STANDBY_OK && !SYS_ON_REQ && watch_done
        |=> (state_q == plrc_pkg::PLRC_ST_OFF) && STATUS.orderly_off && !STATUS.power_loss)
        else $error("Orderly off not reported at end of interval");

    AST_NO_EARLY_OFF: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(state_q == plrc_pkg::PLRC_ST_OFF) && $past(state_q) == plrc_pkg::PLRC_ST_WATCH
        |-> $past(cnt_q) == WATCH_CYCLES - 32'h0000_0001)
        else $error("Supervision ended early");

    AST_LOSS_IN_WATCH: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_q == plrc_pkg::PLRC_ST_WATCH) && !STANDBY_OK
        |=> (state_q == plrc_pkg::PLRC_ST_LOST) && STATUS.power_loss && SUPPLY_ON_REQUEST_N)
        else $error("Power loss inside interval not classified");

    AST_TURN_ON: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_q == plrc_pkg::PLRC_ST_DECIDE) && STANDBY_OK && STANDBY_RAIL_PRESENT
        && (policy == plrc_pkg::PLRC_POL_TURN_ON)
        |=> !SUPPLY_ON_REQUEST_N)
        else $error("Turn-on policy did not switch on");

    AST_REMAIN_OFF: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_q == plrc_pkg::PLRC_ST_DECIDE) && STANDBY_RAIL_PRESENT
        && (policy == plrc_pkg::PLRC_POL_REMAIN_OFF)
        |=> SUPPLY_ON_REQUEST_N)
        else $error("Remain-off policy switched on");

    AST_LAST_STATE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_q == plrc_pkg::PLRC_ST_DECIDE) && STANDBY_OK && STANDBY_RAIL_PRESENT && is_last
        |=> SUPPLY_ON_REQUEST_N == !$past(rec_rd.last_on))
        else $error("Last-state policy did not restore record");

    AST_NO_WATCH_OTHER: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_q == plrc_pkg::PLRC_ST_ON) && STANDBY_OK && SYS_OFF_REQ && !is_last
        |=> (state_q == plrc_pkg::PLRC_ST_OFF) && !STATUS.supervising)
        else $error("Supervision used outside last-state policy");

    AST_NO_RAIL: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_q == plrc_pkg::PLRC_ST_DECIDE) && STANDBY_OK && !STANDBY_RAIL_PRESENT
        |=> !SUPPLY_ON_REQUEST_N)
        else $error("Policy acted without standby rail");

    AST_RECORD_HELD: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_q == plrc_pkg::PLRC_ST_WATCH) && STANDBY_OK
        |-> !nv_wr || enter_on || orderly_evt)
        else $error("Record changed inside interval");

    AST_SUPPLY_PIN: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ##1 (SUPPLY_ON_REQUEST_N == (state_q != plrc_pkg::PLRC_ST_ON)))
        else $error("Supply request does not follow on state");

    AST_PERSIST_ON: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(state_q == plrc_pkg::PLRC_ST_ON)
        |-> $past(nv_wr) && $past(rec_wr.last_on) ##1 rec_rd.last_on)
        else $error("On transition not persisted");

endmodule : plrc_top

`default_nettype wire

// *** testbench/plrc_atx_model.sv ***
/*
 * Behavioural model of an ATX-style supply with a standby rail, including
 * the standby-powered inverter that turns the supply-on request around.
 * Assumes the bench drives ac_present on the falling edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none

module plrc_atx_model #(
    parameter int STBY_DLY = 3,
    parameter int MAIN_DLY = 2
) (
    // Clock and mains
    input  wire logic clk,
    input  wire logic ac_present,
    // Supply control
    input  wire logic supply_on_request_n,
    // Rails
    output logic      standby_ok,
    output logic      main_good
);
    int   stby_cnt;
    int   main_cnt;
    logic inv_on;

    // ------------------------------------------------------------------------
    // Rails
    // ------------------------------------------------------------------------
    // Inverter sits on standby, so the main rails die with standby
    assign inv_on = standby_ok & ~supply_on_request_n;

    initial begin
        standby_ok = 1'b0;
        main_good  = 1'b0;
        stby_cnt   = 0;
        main_cnt   = 0;
    end

    // Standby comes up slowly, drops at once
    always @(negedge clk) begin
        if (!ac_present) begin
            stby_cnt   <= 0;
            standby_ok <= 1'b0;
        end else if (stby_cnt < STBY_DLY) begin
            stby_cnt <= stby_cnt + 1;
        end else begin
            standby_ok <= 1'b1;
        end
    end

    always @(negedge clk) begin
        if (!inv_on) begin
            main_cnt  <= 0;
            main_good <= 1'b0;
        end else if (main_cnt < MAIN_DLY) begin
            main_cnt <= main_cnt + 1;
        end else begin
            main_good <= 1'b1;
        end
    end
endmodule : plrc_atx_model

`default_nettype wire

// *** testbench/tb.sv ***
/*
 * Self-checking bench of the power loss restore controller.
 * Assumes the supply model above and a shortened supervision interval.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int WATCH_N  = 20;
    localparam int MAIN_DLY = 2;

    logic                   sys_clk;
    logic                   rst_n;
    logic                   ac_present;
    logic                   standby_ok;
    logic                   rail_present;
    logic [1:0]             policy;
    logic                   on_req;
    logic                   off_req;
    logic                   supply_n;
    logic                   main_good;
    plrc_pkg::plrc_status_t status;
    int                     err_count;
    int                     total_checks;

    always #5 sys_clk = ~sys_clk;

    plrc_top #(.WATCH_CYCLES(32'(WATCH_N))) uut (
        .SYS_CLK             (sys_clk),
        .RST_N               (rst_n),
        .STANDBY_OK          (standby_ok),
        .STANDBY_RAIL_PRESENT(rail_present),
        .POLICY              (policy),
        .SYS_ON_REQ          (on_req),
        .SYS_OFF_REQ         (off_req),
        .SUPPLY_ON_REQUEST_N (supply_n),
        .STATUS              (status)
    );

    plrc_atx_model #(.STBY_DLY(3), .MAIN_DLY(MAIN_DLY)) psu (
        .clk                (sys_clk),
        .ac_present         (ac_present),
        .supply_on_request_n(supply_n),
        .standby_ok         (standby_ok),
        .main_good          (main_good)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic check_st(input logic [2:0] st);
        check({5'h00, status.state}, {5'h00, st});
    endtask : check_st

    task automatic tick();
        @(negedge sys_clk);
    endtask : tick

    task automatic timeout(input string what);
        err_count++;
        $display("Error at %0t: timeout waiting for %s", $time, what);
        final_report();
    endtask : timeout

    // Drop mains, see the loss, bring mains back, judge the restore
    task automatic restore(input logic [1:0] pol, input logic rail, input logic exp_on);
        int n;
        n            = 0;
        policy       = pol;
        rail_present = rail;
        ac_present   <= 1'b0;
        while (status.power_loss !== 1'b1) begin
            tick();
            n++;
            if (n > 8) timeout("power loss");
        end
        check(8'(status.orderly_off), 8'h00);
        check_st(plrc_pkg::PLRC_ST_LOST);
        check(8'(supply_n), 8'h01);
        tick();
        check(8'(status.power_loss), 8'h00);
        ac_present <= 1'b1;
        n = 0;
        while (status.state !== plrc_pkg::PLRC_ST_ON && status.state !== plrc_pkg::PLRC_ST_OFF) begin
            tick();
            n++;
            if (n > 20) timeout("restore");
        end
        check(8'(status.system_on), 8'(exp_on));
        check(8'(supply_n), 8'(!exp_on));
        repeat (MAIN_DLY + 2) tick();
        check(8'(main_good), 8'(exp_on));
    endtask : restore

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_power_up();
        int n;
        n = 0;
        while (status.state !== plrc_pkg::PLRC_ST_ON && status.state !== plrc_pkg::PLRC_ST_OFF) begin
            tick();
            n++;
            if (n > 8) timeout("power up");
        end
        check_st(plrc_pkg::PLRC_ST_OFF);
        check(8'(supply_n), 8'h01);
        check(8'(status.supervising), 8'h00);
        $display("test power_up done");
    endtask : t_power_up

    task automatic t_policies();
        restore(2'h0, 1'b1, 1'b1);
        restore(2'h1, 1'b1, 1'b0);
        restore(2'h3, 1'b1, 1'b0);
        restore(2'h1, 1'b0, 1'b1);
        restore(2'h2, 1'b1, 1'b1);
        $display("test policies done");
    endtask : t_policies

    task automatic t_orderly_off();
        int n;
        policy  = 2'h2;
        off_req = 1'b1;
        tick();
        off_req = 1'b0;
        check(8'(supply_n), 8'h01);
        check(8'(status.supervising), 8'h01);
        n = 0;
        while (status.supervising === 1'b1 && n < 100) begin
            n++;
            tick();
        end
        check(8'(n), 8'(WATCH_N));
        check(8'(status.orderly_off), 8'h01);
        check_st(plrc_pkg::PLRC_ST_OFF);
        tick();
        check(8'(status.orderly_off), 8'h00);
        restore(2'h2, 1'b1, 1'b0);
        $display("test orderly_off done");
    endtask : t_orderly_off

    task automatic t_wake();
        on_req = 1'b1;
        tick();
        on_req = 1'b0;
        check(8'(status.system_on), 8'h01);
        check(8'(supply_n), 8'h00);
        check_st(plrc_pkg::PLRC_ST_ON);
        $display("test wake done");
    endtask : t_wake

    task automatic t_loss_in_window();
        policy  = 2'h2;
        off_req = 1'b1;
        tick();
        off_req = 1'b0;
        repeat (5) tick();
        check(8'(status.supervising), 8'h01);
        // Record still says on, so last-state powers back up
        restore(2'h2, 1'b1, 1'b1);
        $display("test loss_in_window done");
    endtask : t_loss_in_window

    task automatic t_direct_off();
        policy  = 2'h0;
        off_req = 1'b1;
        tick();
        off_req = 1'b0;
        check_st(plrc_pkg::PLRC_ST_OFF);
        check(8'(status.supervising), 8'h00);
        check(8'(supply_n), 8'h01);
        $display("test direct_off done");
    endtask : t_direct_off

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        sys_clk      = 1'b0;
        rst_n        = 1'b0;
        ac_present   = 1'b1;
        rail_present = 1'b1;
        policy       = 2'h1;
        on_req       = 1'b0;
        off_req      = 1'b0;
        err_count    = 0;
        total_checks = 0;
        repeat (16) tick();
        rst_n = 1'b1;
        t_power_up();
        t_policies();
        t_orderly_off();
        t_wake();
        t_loss_in_window();
        t_direct_off();
        final_report();
    end
endmodule : tb

`default_nettype wire
